// ===== verilog/diag_pkg.sv
// Constants, types and register map of the diagnostic control block.
// Behaviour
// R1: When enabled, take a reference CRC, then recheck periodically.
// R2: Any difference from the reference sets the integrity error flag.
// R3: The map CRC runs only while its enable bit holds 1.
// R4: Failure reads 1; writing 1 clears the flag, writing 0 leaves it.
// R5: Burnout amplitude selects 0.1, 2 or 10 microamps for both generators.
// R6: Source and sink generators always switch together.
// R7: Burnout enable and amplitude are held per channel.
// R8: Burnout currents flow only while that channel is being converted.
// R9: A zero burnout field turns that channel's currents off.
// R10: Enabled pull-up currents stay on continuously on their pins.
// R11: Pull-ups are enabled per pin through a dedicated register.
// R12: Temperature sensor routes when both input selects choose it.
// R13: Bridge switch stays closed in standby when its keep bit is 1.
// R14: Modulator clock is main clock over four times the divide setting.
// R15: Host waits for ready low, reads result, repeats.
// R16: Integrity flag stays set until the host clears it.
// R17: Reference is re-taken only by disabling and re-enabling checking.
`default_nettype none
package diag_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_PINS = 8;
    localparam int SEL_W = 5;
    localparam int ADDR_W = 8;
    // Register byte addresses.
    localparam logic [ADDR_W-1:0] ADDR_ERR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ERR_ENABLE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PULL_UP = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_SEQ_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_DRIVE = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_MAP_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_MISC_BASE = 8'h30;
    // Field positions.
    localparam int BIT_MAP_ERR = 0;
    localparam int POS_NEG_SEL = 8;
    localparam int POS_BURNOUT = 0;
    localparam int POS_STB_KEEP = 2;
    localparam int POS_SEQ_CH = 0;
    localparam int POS_STANDBY = 4;
    localparam int POS_CLK_DIV = 8;
    // Reset values.
    localparam logic [3:0] CLK_DIV_RESET = 4'h2;
    // Modulator half period, in main clocks per step of the divide setting.
    localparam int MOD_HALF_PER_DIV = 2;
    localparam logic [SEL_W-1:0] TEMP_SENSOR_SEL = 5'h10;
    // Burnout amplitude codes; zero means off.
    localparam logic [1:0] BURN_OFF = 2'h0;
    localparam logic [1:0] BURN_100NA = 2'h1;
    localparam logic [1:0] BURN_2UA = 2'h2;
    localparam logic [1:0] BURN_10UA = 2'h3;
    // Time between checks of the register map.
    localparam int RECHECK_US = 100;
    localparam int CLK_MHZ = 10;
    localparam int RECHECK_CYCLES = RECHECK_US * CLK_MHZ;
    localparam logic [7:0] CRC_SEED = 8'hA5;
    typedef enum logic [1:0] {CRC_IDLE, CRC_REF, CRC_WAIT,
        CRC_CHECK} crc_state_e;
    typedef logic [7:0] crc_t;
endpackage
`default_nettype wire

// ===== verilog/crc_if.sv
// Interface between the diagnostic top and its CRC engine.
`default_nettype none
interface crc_if;
    logic start;
    logic [31:0] data;
    logic busy;
    logic [7:0] result;
    modport ctrl (output start, output data, input busy, input result);
    modport engine (input start, input data, output busy, output result);
endinterface
`default_nettype wire

// ===== verilog/map_crc_engine.sv
// CRC-8 engine that folds one 32-bit image word per start, one bit a cycle.
`default_nettype none
module map_crc_engine
    import diag_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    crc_if.engine port
);
    logic [31:0] shreg;
    logic [5:0] count;
    crc_t crc;

    function automatic crc_t crc_bit(input crc_t c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        crc_bit = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    endfunction

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            count <= 6'h00;
            shreg <= 32'h0000_0000;
            crc <= CRC_SEED;
        end
        else if (port.start && count == 6'h00)
        begin
            count <= 6'h20;
            shreg <= port.data;
            crc <= CRC_SEED;
        end
        else if (count != 6'h00)
        begin
            count <= count - 6'h01;
            shreg <= {shreg[30:0], 1'b0};
            crc <= crc_bit(crc, shreg[31]);
        end
    end

    assign port.busy = (count != 6'h00);
    assign port.result = crc;
endmodule
`default_nettype wire

// ===== verilog/diag_ctrl.sv
// Diagnostic control: map integrity check, burnout, pull-ups, routing.
`default_nettype none
module diag_ctrl
    import diag_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sequencer and standby inputs from pins
    input wire logic [1:0] active_channel_pin,
    input wire logic standby_pin,
    // Analog controls
    output logic burnout_source_en,
    output logic burnout_sink_en,
    output logic [1:0] burnout_amplitude,
    output logic [NUM_PINS-1:0] pull_up_en,
    output logic temp_sensor_routed,
    output logic bridge_switch_closed,
    output logic mod_clk,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic map_integrity_error_flag;
    logic map_integrity_check_enable;
    logic irq_mask;
    logic [NUM_PINS-1:0] pull_up;
    logic [3:0] clk_div;
    logic drive_standby;
    logic [SEL_W-1:0] positive_input_select [NUM_CH];
    logic [SEL_W-1:0] negative_input_select [NUM_CH];
    logic [1:0] channel_misc_config [NUM_CH];
    logic standby_switch_keep [NUM_CH];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [1:0] active_channel;
    logic standby;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end
        else
        begin
            sync_a <= {standby_pin, active_channel_pin};
            sync_b <= sync_a;
        end
    end

    assign active_channel = sync_b[1:0];
    assign standby = sync_b[2];

    // ------------------------------------------------------------------
    // AHB-Lite address phase
    // ------------------------------------------------------------------
    logic wr_pend;
    logic rd_pend;
    logic [ADDR_W-1:0] addr_q;
    logic take;

    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            if (take)
            begin
                addr_q <= haddr[ADDR_W-1:0];
            end
        end
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] base, input int i);
        hit = (a == base + ADDR_W'(4 * i));
    endfunction

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            map_integrity_check_enable <= 1'b0;
            irq_mask <= 1'b0;
            pull_up <= '0;
            clk_div <= CLK_DIV_RESET;
            drive_standby <= 1'b0;
            for (int i = 0; i < NUM_CH; i++)
            begin
                positive_input_select[i] <= '0;
                negative_input_select[i] <= '0;
                channel_misc_config[i] <= BURN_OFF;
                standby_switch_keep[i] <= 1'b0;
            end
        end
        else if (wr_pend)
        begin
            if (addr_q == ADDR_ERR_ENABLE)
                map_integrity_check_enable <= hwdata[BIT_MAP_ERR]; // R3
            if (addr_q == ADDR_IRQ_MASK)
                irq_mask <= hwdata[BIT_MAP_ERR];
            if (addr_q == ADDR_PULL_UP)
                pull_up <= hwdata[NUM_PINS-1:0]; // R11
            if (addr_q == ADDR_SEQ_CTRL)
            begin
                drive_standby <= hwdata[POS_STANDBY];
                clk_div <= hwdata[POS_CLK_DIV +: 4];
            end
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (hit(addr_q, ADDR_MAP_BASE, i))
                begin
                    positive_input_select[i] <= hwdata[SEL_W-1:0];
                    negative_input_select[i] <= hwdata[POS_NEG_SEL +: SEL_W];
                end
                if (hit(addr_q, ADDR_MISC_BASE, i))
                begin
                    channel_misc_config[i] <= hwdata[POS_BURNOUT +: 2]; // R7
                    standby_switch_keep[i] <= hwdata[POS_STB_KEEP];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Map image and CRC check
    // ------------------------------------------------------------------
    crc_if crc_port ();
    map_crc_engine u_engine (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .port(crc_port.engine)
    );

    logic [31:0] image [NUM_CH + 2];
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            image[i] = {16'h0000, 3'h0, negative_input_select[i], 3'h0,
                positive_input_select[i]};
            image[i][31:24] = {5'h00, standby_switch_keep[i],
                channel_misc_config[i]};
        end
        image[NUM_CH] = {24'h000000, pull_up};
        image[NUM_CH + 1] = {20'h00000, clk_div, 3'h0, drive_standby,
            4'h0};
    end

    crc_state_e state;
    logic [2:0] word_idx;
    logic [15:0] wait_cnt;
    crc_t running;
    crc_t reference;
    logic mismatch;
    logic final_word;
    logic sent;

    assign final_word = (word_idx == 3'(NUM_CH + 1));
    assign crc_port.data = image[word_idx] ^ {24'h000000, running};
    assign crc_port.start = (state == CRC_REF || state == CRC_CHECK)
        && !crc_port.busy && !sent;

    always_ff @(posedge clk_sys)
    begin
        mismatch <= 1'b0;
        if (sys_rst || !map_integrity_check_enable) // R3 R17
        begin
            state <= CRC_IDLE;
            word_idx <= 3'h0;
            wait_cnt <= '0;
            running <= CRC_SEED;
            reference <= CRC_SEED;
            sent <= 1'b0;
        end
        else
        begin
            unique case (state)
                CRC_IDLE:
                begin
                    state <= CRC_REF; // R1
                    word_idx <= 3'h0;
                    running <= CRC_SEED;
                end
                CRC_REF, CRC_CHECK:
                begin
                    if (crc_port.start)
                        sent <= 1'b1;
                    else if (sent && !crc_port.busy)
                    begin
                        sent <= 1'b0;
                        running <= crc_port.result;
                        word_idx <= word_idx + 3'h1;
                        if (final_word)
                        begin
                            word_idx <= 3'h0;
                            running <= CRC_SEED;
                            wait_cnt <= 16'(RECHECK_CYCLES);
                            state <= CRC_WAIT;
                            if (state == CRC_REF)
                                reference <= crc_port.result; // R1
                            else
                                mismatch <= crc_port.result != reference; // R2
                        end
                    end
                end
                CRC_WAIT:
                begin
                    wait_cnt <= wait_cnt - 16'h0001;
                    if (wait_cnt == 16'h0001)
                        state <= CRC_CHECK; // R1
                end
            endcase
        end
    end

    // Sticky flag: set wins over a clearing write.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            map_integrity_error_flag <= 1'b0;
        else if (mismatch)
            map_integrity_error_flag <= 1'b1; // R2 R16
        else if (wr_pend && addr_q == ADDR_ERR_STATUS
            && hwdata[BIT_MAP_ERR])
            map_integrity_error_flag <= 1'b0; // R4
    end

    assign irq = map_integrity_error_flag && irq_mask;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
        begin
            hrdata <= 32'h0000_0000;
            unique case (haddr[ADDR_W-1:0])
                ADDR_ERR_STATUS:
                    hrdata[BIT_MAP_ERR] <= map_integrity_error_flag; // R4
                ADDR_ERR_ENABLE:
                    hrdata[BIT_MAP_ERR] <= map_integrity_check_enable;
                ADDR_IRQ_MASK: hrdata[BIT_MAP_ERR] <= irq_mask;
                ADDR_PULL_UP: hrdata[NUM_PINS-1:0] <= pull_up;
                ADDR_SEQ_CTRL: hrdata <= image[NUM_CH + 1];
                default:
                begin
                    for (int i = 0; i < NUM_CH; i++)
                    begin
                        if (hit(haddr[ADDR_W-1:0], ADDR_MAP_BASE, i))
                            hrdata <= {16'h0000, image[i][15:0]};
                        if (hit(haddr[ADDR_W-1:0], ADDR_MISC_BASE, i))
                            hrdata <= {24'h000000, image[i][31:24]};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------------
    logic [1:0] sel_burn;
    assign sel_burn = channel_misc_config[active_channel]; // R8

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            burnout_source_en <= 1'b0;
            burnout_sink_en <= 1'b0;
            burnout_amplitude <= BURN_OFF;
        end
        else
        begin
            burnout_source_en <= sel_burn != BURN_OFF; // R6 R9
            burnout_sink_en <= sel_burn != BURN_OFF; // R6 R9
            burnout_amplitude <= sel_burn; // R5
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pull_up_en <= '0;
            temp_sensor_routed <= 1'b0;
            bridge_switch_closed <= 1'b0;
        end
        else
        begin
            pull_up_en <= pull_up; // R10
            temp_sensor_routed <=
                positive_input_select[active_channel] == TEMP_SENSOR_SEL &&
                negative_input_select[active_channel] == TEMP_SENSOR_SEL; // R12
            bridge_switch_closed <= !(standby || drive_standby)
                || standby_switch_keep[active_channel]; // R13
        end
    end

    // Modulator clock divider: each half period lasts 2 * clk_div cycles.
    logic [4:0] div_cnt;
    logic [4:0] div_half;
    assign div_half = 5'(MOD_HALF_PER_DIV) * {1'b0, clk_div};

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            div_cnt <= 5'h00;
            mod_clk <= 1'b0;
        end
        else if (div_cnt + 5'h01 >= div_half)
        begin
            div_cnt <= 5'h00;
            mod_clk <= !mod_clk; // R14
        end
        else
            div_cnt <= div_cnt + 5'h01;
    end
endmodule
`default_nettype wire

// ===== dv/diag_ctrl_properties.sv
// Concurrent checks on the ports of the diagnostic control block.
`default_nettype none
module diag_ctrl_properties
    import diag_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Watched outputs
    input wire logic burnout_source_en,
    input wire logic burnout_sink_en,
    input wire logic [1:0] burnout_amplitude,
    input wire logic [NUM_PINS-1:0] pull_up_en,
    input wire logic mod_clk,
    input wire logic irq
);
    logic dp_wr;
    logic [7:0] dp_adr;
    logic en_seen;
    logic [NUM_PINS-1:0] pu_q;
    logic wr_st;
    logic wr_en;
    logic wr_msk;
    logic wr_pu;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    assign wr_st = dp_wr && dp_adr == ADDR_ERR_STATUS && hwdata[0];
    assign wr_en = dp_wr && dp_adr == ADDR_ERR_ENABLE && hwdata[0];
    assign wr_msk = dp_wr && dp_adr == ADDR_IRQ_MASK && !hwdata[0];
    assign wr_pu = dp_wr && dp_adr == ADDR_PULL_UP;
    // ----------------------------------------
    // Data phase tracking
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            dp_wr <= 1'b0;
            dp_adr <= 8'h00;
        end
        else
        begin
            dp_wr <= hsel && hready && htrans[1] && hwrite;
            dp_adr <= haddr[7:0];
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            en_seen <= 1'b0;
        else if (wr_en)
            en_seen <= 1'b1;
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            pu_q <= '0;
        else if (wr_pu)
            pu_q <= hwdata[NUM_PINS-1:0];
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    gen_pair_a: assert property (burnout_source_en == burnout_sink_en)
        else $error("burnout generators differ");
    zero_off_a: assert property
        (burnout_source_en == (burnout_amplitude != 2'h0))
        else $error("burnout enable does not follow amplitude");
    flag_sticky_a: assert property
        ($fell(irq) |-> $past(wr_st) || $past(wr_msk))
        else $error("interrupt fell without a clear");
    mask_off_a: assert property (wr_msk |=> !irq)
        else $error("interrupt high while masked");
    check_gated_a: assert property (!en_seen |-> !irq)
        else $error("error flag set while checking never enabled");
    pull_value_a: assert property
        ($changed(pull_up_en) |-> pull_up_en == pu_q)
        else $error("pull-up enables differ from written value");
    pull_steady_a: assert property
        ($changed(pull_up_en) |-> $past(wr_pu) || $past(wr_pu, 2))
        else $error("pull-up enables changed without a write");
    mod_div_a: assert property
        ($changed(mod_clk) |=> $stable(mod_clk) [*3])
        else $error("modulator half period too short");
endmodule
bind diag_ctrl diag_ctrl_properties u_diag_ctrl_properties (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .burnout_source_en(burnout_source_en),
    .burnout_sink_en(burnout_sink_en),
    .burnout_amplitude(burnout_amplitude), .pull_up_en(pull_up_en),
    .mod_clk(mod_clk), .irq(irq));
`default_nettype wire

// ===== dv/diag_ctrl_tb.sv
// Self-checking testbench of the diagnostic control block.
`default_nettype none
module diag_ctrl_tb
    import diag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] active_channel_pin = 2'h0;
    logic standby_pin = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic src_en;
    wire logic snk_en;
    wire logic [1:0] amp;
    wire logic [NUM_PINS-1:0] pull_up_en;
    wire logic temp_sensor_routed;
    wire logic bridge_switch_closed;
    wire logic mod_clk;
    wire logic irq;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] q;
    diag_ctrl u_diag_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .active_channel_pin(active_channel_pin), .standby_pin(standby_pin),
        .burnout_source_en(src_en), .burnout_sink_en(snk_en),
        .burnout_amplitude(amp), .pull_up_en(pull_up_en),
        .temp_sensor_routed(temp_sensor_routed),
        .bridge_switch_closed(bridge_switch_closed), .mod_clk(mod_clk),
        .irq(irq));
    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done();
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask
    task automatic ch(input logic [1:0] c);
        @(posedge clk_sys);
        active_channel_pin <= c;
        cyc(6);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 3000)
        begin
            @(posedge clk_sys);
            k++;
        end
        #10;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        ahb(1'b0, ADDR_SEQ_CTRL, 32'h0);
        chk((q >> POS_CLK_DIV) & 32'hF, {28'h0, CLK_DIV_RESET});
        ahb(1'b1, 8'h80, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h80, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        @(posedge mod_clk);
        repeat (4) @(negedge clk_sys);
        chk({31'h0, mod_clk}, 32'h1);
        @(negedge clk_sys);
        chk({31'h0, mod_clk}, 32'h0);
    endtask
    task automatic t_pullup();
        ahb(1'b1, ADDR_PULL_UP, 32'hA5);
        cyc(3);
        for (int c = 0; c < 4; c++)
        begin
            ch(c[1:0]);
            chk({24'h0, pull_up_en}, 32'hA5);
        end
    endtask
    task automatic t_burnout();
        for (int c = 0; c < 4; c++)
            ahb(1'b1, ADDR_MISC_BASE + 8'(4 * c), c);
        for (int c = 0; c < 4; c++)
        begin
            ch(c[1:0]);
            chk({30'h0, amp}, c);
            chk({31'h0, src_en}, {31'h0, c != 0});
            chk({31'h0, snk_en}, {31'h0, c != 0});
        end
    endtask
    task automatic t_temp();
        ahb(1'b1, ADDR_MAP_BASE + 8'h08, 32'h1010);
        ahb(1'b1, ADDR_MAP_BASE + 8'h04, 32'h0110);
        ch(2'h2);
        chk({31'h0, temp_sensor_routed}, 32'h1);
        ch(2'h1);
        chk({31'h0, temp_sensor_routed}, 32'h0);
    endtask
    task automatic t_bridge();
        ahb(1'b1, ADDR_MISC_BASE + 8'h0C, 32'h3);
        ahb(1'b1, ADDR_SEQ_CTRL, 32'h210);
        ch(2'h3);
        chk({31'h0, bridge_switch_closed}, 32'h0);
        ahb(1'b1, ADDR_MISC_BASE + 8'h0C, 32'h7);
        cyc(4);
        chk({31'h0, bridge_switch_closed}, 32'h1);
        ahb(1'b1, ADDR_MISC_BASE + 8'h0C, 32'h3);
        ahb(1'b1, ADDR_SEQ_CTRL, 32'h200);
        @(posedge clk_sys);
        standby_pin <= 1'b1;
        cyc(6);
        chk({31'h0, bridge_switch_closed}, 32'h0);
        @(posedge clk_sys);
        standby_pin <= 1'b0;
        cyc(6);
        chk({31'h0, bridge_switch_closed}, 32'h1);
    endtask
    task automatic t_crc();
        ahb(1'b1, ADDR_IRQ_MASK, 32'h1);
        cyc(2500);
        ahb(1'b0, ADDR_ERR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        ahb(1'b1, ADDR_ERR_ENABLE, 32'h1);
        cyc(2500);
        ahb(1'b0, ADDR_ERR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        ahb(1'b1, ADDR_MAP_BASE, 32'h0203);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        ahb(1'b1, ADDR_ERR_STATUS, 32'h0);
        cyc(1500);
        ahb(1'b0, ADDR_ERR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h1);
        ahb(1'b1, ADDR_IRQ_MASK, 32'h0);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        ahb(1'b1, ADDR_IRQ_MASK, 32'h1);
        ahb(1'b1, ADDR_ERR_STATUS, 32'h1);
        ahb(1'b0, ADDR_ERR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        wait_irq();
        chk({31'h0, irq}, 32'h1);
        ahb(1'b1, ADDR_MAP_BASE, 32'h0);
        cyc(2500);
        ahb(1'b0, ADDR_ERR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h1);
        ahb(1'b1, ADDR_ERR_ENABLE, 32'h0);
        ahb(1'b1, ADDR_ERR_ENABLE, 32'h1);
        ahb(1'b1, ADDR_ERR_STATUS, 32'h1);
        cyc(2500);
        ahb(1'b0, ADDR_ERR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_pullup();
        t_burnout();
        t_temp();
        t_bridge();
        t_crc();
        test_done();
    end
endmodule
`default_nettype wire
